/* hdl/sfr_read_seq.sv */
// Summary of operation
// [RL1] command starts at select fall, opcode, address
// [RL2] all shifting is most significant bit first
// [RL3] serial clock mode 0 or 3 accepted
// [RL4] legacy array read: three address, four dummies
// [RL5] long pages: 12-bit page, 10-bit byte
// [RL6] short pages: 12-bit page, 9-bit byte
// [RL7] main array holds 4096 selectable pages
// [RL8] address counter advances as data streams
// [RL9] page end continues into next page seamlessly
// [RL10] array end wraps to page zero seamlessly
// [RL11] select rise ends read, output floats
// [RL12] host holds select low whole command
// [RL13] fast array read: exactly one dummy
// [RL14] host keeps fast reads within fast limit
// [RL15] slow array read: no dummy, slow clock
// [RL16] array reads never touch the buffers
// [RL17] page read: three address, four dummies
// [RL18] page read wraps within same page
// [RL19] four buffer read opcodes pick buffer
// [RL20] host uses slow buffer opcodes slowly
// [RL21] long buffer: 14 ignored, 10-bit offset
// [RL22] short buffer: 15 ignored, 9-bit offset
// [RL23] buffer read needs one dummy byte
// [RL24] buffer end wraps to byte zero
// [RL25] output bits change after falling edges
`default_nettype none
module sfr_read_seq #(
    parameter int FIFO_DEPTH = sfr_pkg::FIFO_WORDS
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  cs_n_in,
    input  wire logic                  sck_in,
    input  wire logic                  si_in,
    input  wire logic                  page_512_in,
    input  wire logic [7:0]            mem_data_in,
    output logic                       so_out,
    output logic                       so_oe_n_out,
    output logic                       mem_rd_out,
    output sfr_pkg::sfr_mem_req_s      mem_req_out
);
    import sfr_pkg::*;

    // ----------------------------------------------------------------
    // types and signals
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_OPCODE = 6'b000010,
        ST_ADDR   = 6'b000100,
        ST_DUMMY  = 6'b001000,
        ST_DATA   = 6'b010000,
        ST_IGNORE = 6'b100000
    } sfr_state_e;

    sfr_state_e           state;
    sfr_cmd_s             cmd;
    sfr_cmd_s             op_dec;
    logic                 sck_q;
    logic [2:0]           bit_cnt;
    logic [1:0]           hdr_cnt;
    logic [2:0]           dummy_cnt;
    logic [7:0]           in_shift;
    logic [15:0]          addr_hi;
    logic [7:0]           in_byte;
    logic [23:0]          full_addr;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 byte_done;
    logic                 addr_done;
    logic                 fetch_on;
    logic                 issue;
    logic [PAGE_BITS-1:0] page_cnt;
    logic [COL_BITS-1:0]  col_cnt;
    logic [COL_BITS-1:0]  last_col;
    logic                 at_last_col;
    logic [2:0]           out_cnt;
    logic [7:0]           out_shift;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic [7:0]           fifo_out_data;
    logic                 fifo_pop;

    // ----------------------------------------------------------------
    // opcode decode
    // ----------------------------------------------------------------
    function automatic sfr_cmd_s decode_op(input logic [7:0] op);
        sfr_cmd_s c;
        c.valid     = 1'b1;
        c.src       = SRC_ARRAY;
        c.same_page = 1'b0;
        c.dummies   = DUMMY_NONE;
        case (op)
            OP_ARRAY_LEGACY: begin
                c.dummies = DUMMY_LEGACY; // [RL4]
            end
            OP_ARRAY_FAST: begin
                c.dummies = DUMMY_FAST; // [RL13]
            end
            OP_ARRAY_SLOW: begin
                c.dummies = DUMMY_NONE; // [RL15]
            end
            OP_PAGE_READ: begin
                c.dummies   = DUMMY_PAGE; // [RL17]
                c.same_page = 1'b1;
            end
            OP_BUF1_FAST, OP_BUF1_SLOW: begin
                c.src     = SRC_BUF1; // [RL19]
                c.dummies = DUMMY_BUF; // [RL23]
            end
            OP_BUF2_FAST, OP_BUF2_SLOW: begin
                c.src     = SRC_BUF2; // [RL19]
                c.dummies = DUMMY_BUF; // [RL23]
            end
            default: begin
                c.valid = 1'b0;
            end
        endcase
        return c;
    endfunction

    // ----------------------------------------------------------------
    // serial clock edges
    // ----------------------------------------------------------------
    // either idle level of the clock works: only edges seen while
    // selected count, and a falling edge before data is harmless
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck_in;
        end
    end

    assign sck_rise  = ~sck_q & sck_in & ~cs_n_in; // [RL3]
    assign sck_fall  = sck_q & ~sck_in & ~cs_n_in; // [RL3]
    assign in_byte   = {in_shift[6:0], si_in}; // [RL2]
    assign op_dec    = decode_op(in_byte); // [RL19]
    assign byte_done = sck_rise && (bit_cnt == LAST_BIT) && (state != ST_DATA);
    assign full_addr = {addr_hi, in_byte};
    assign addr_done = (state == ST_ADDR) && byte_done && (hdr_cnt == LAST_ADDR_BYTE);

    // ----------------------------------------------------------------
    // input shifter
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bit_cnt  <= 3'h0;
            in_shift <= 8'h00;
        end else if (cs_n_in) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise && state != ST_DATA) begin
            bit_cnt  <= bit_cnt + 3'h1;
            in_shift <= in_byte; // [RL2]
        end
    end

    // ----------------------------------------------------------------
    // command sequence
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state     <= ST_IDLE;
            cmd       <= '0;
            hdr_cnt   <= 2'h0;
            dummy_cnt <= 3'h0;
            addr_hi   <= 16'h0000;
        end else if (cs_n_in) begin
            state <= ST_IDLE; // [RL11]
        end else begin
            case (state)
                ST_IDLE: begin
                    state   <= ST_OPCODE; // [RL1]
                    hdr_cnt <= 2'h0;
                end
                ST_OPCODE: begin
                    if (byte_done) begin
                        cmd   <= op_dec; // [RL1]
                        state <= op_dec.valid ? ST_ADDR : ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        addr_hi <= full_addr[15:0];
                        hdr_cnt <= hdr_cnt + 2'h1;
                        if (hdr_cnt == LAST_ADDR_BYTE) begin
                            dummy_cnt <= 3'h0;
                            // slow array read streams straight after address
                            state <= (cmd.dummies == DUMMY_NONE) ? ST_DATA : ST_DUMMY; // [RL15]
                        end
                    end
                end
                ST_DUMMY: begin
                    if (byte_done) begin
                        dummy_cnt <= dummy_cnt + 3'h1;
                        if (dummy_cnt + 3'h1 == cmd.dummies) begin
                            state <= ST_DATA; // [RL4] [RL13] [RL17] [RL23]
                        end
                    end
                end
                ST_DATA: begin
                    state <= ST_DATA;
                end
                ST_IGNORE: begin
                    state <= ST_IGNORE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // address counter and memory fetch
    // ----------------------------------------------------------------
    assign last_col    = page_512_in ? LAST_COL_SHORT : LAST_COL_LONG;
    assign at_last_col = col_cnt == last_col;
    // one read in flight at most, so a pushed byte always has room
    assign issue = fetch_on & ~mem_rd_out & fifo_in_ready;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fetch_on <= 1'b0;
            page_cnt <= '0;
            col_cnt  <= '0;
        end else if (cs_n_in) begin
            fetch_on <= 1'b0;
        end else if (addr_done) begin
            // prefetch during the dummy bytes hides memory latency
            fetch_on <= 1'b1;
            if (cmd.src != SRC_ARRAY) begin
                page_cnt <= '0;
                if (page_512_in) begin
                    col_cnt <= {1'b0, full_addr[8:0]}; // [RL22]
                end else begin
                    col_cnt <= full_addr[9:0]; // [RL21]
                end
            end else if (page_512_in) begin
                page_cnt <= full_addr[SHORT_PAGE_LSB +: PAGE_BITS]; // [RL6] [RL7]
                col_cnt  <= {1'b0, full_addr[8:0]}; // [RL6]
            end else begin
                page_cnt <= full_addr[LONG_PAGE_LSB +: PAGE_BITS]; // [RL5] [RL7]
                col_cnt  <= full_addr[9:0]; // [RL5]
            end
        end else if (issue) begin
            if (at_last_col) begin
                col_cnt <= '0; // [RL18] [RL24]
                if (cmd.src == SRC_ARRAY && !cmd.same_page) begin
                    // 12-bit counter rolls from last page to page zero
                    page_cnt <= page_cnt + 12'h001; // [RL9] [RL10]
                end
            end else begin
                col_cnt <= col_cnt + 10'h001; // [RL8]
            end
        end
    end

    // data is captured in the same cycle as the read strobe
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_rd_out  <= 1'b0;
            mem_req_out <= '0;
        end else begin
            mem_rd_out <= issue;
            if (issue) begin
                // array and page reads only read; buffers stay untouched
                mem_req_out.src                <= cmd.src; // [RL16]
                mem_req_out.page_number_field  <= page_cnt;
                mem_req_out.byte_in_page_field <= col_cnt;
            end
        end
    end

    // ----------------------------------------------------------------
    // data buffer between memory and output shifter
    // ----------------------------------------------------------------
    sfr_fifo #(
        .WIDTH (DATA_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .reset_n_in    (reset_n_in),
        .flush_in      (cs_n_in),
        .in_valid_in   (mem_rd_out),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (mem_data_in),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out_data)
    );

    assign fifo_pop = (state == ST_DATA) && sck_fall && (out_cnt == 3'h0);

    // ----------------------------------------------------------------
    // output shifter
    // ----------------------------------------------------------------
    // an empty buffer at a byte start sends the fill pattern; only a
    // serial clock too fast for the fetch path can cause that
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            so_out      <= 1'b0;
            so_oe_n_out <= 1'b1;
            out_cnt     <= 3'h0;
            out_shift   <= 8'h00;
        end else if (cs_n_in) begin
            so_oe_n_out <= 1'b1; // [RL11]
            out_cnt     <= 3'h0;
        end else if (state == ST_DATA && sck_fall) begin
            so_oe_n_out <= 1'b0;
            out_cnt     <= out_cnt + 3'h1;
            if (out_cnt == 3'h0) begin
                out_shift <= fifo_out_valid ? fifo_out_data : UNDERRUN_FILL;
                so_out    <= fifo_out_valid ? fifo_out_data[7] : UNDERRUN_FILL[7]; // [RL25]
            end else begin
                out_shift <= {out_shift[6:0], 1'b0};
                so_out    <= out_shift[6]; // [RL2] [RL25]
            end
        end
    end
endmodule // sfr_read_seq
`default_nettype wire

/* hdl/sfr_pkg.sv */
`default_nettype none
package sfr_pkg;

    // ----------------------------------------------------------------
    // opcodes of the read commands
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_ARRAY_LEGACY = 8'hE8;
    localparam logic [7:0] OP_ARRAY_FAST   = 8'h0B;
    localparam logic [7:0] OP_ARRAY_SLOW   = 8'h03;
    localparam logic [7:0] OP_PAGE_READ    = 8'hD2;
    localparam logic [7:0] OP_BUF1_FAST    = 8'hD4;
    localparam logic [7:0] OP_BUF1_SLOW    = 8'hD1;
    localparam logic [7:0] OP_BUF2_FAST    = 8'hD6;
    localparam logic [7:0] OP_BUF2_SLOW    = 8'hD3;

    // ----------------------------------------------------------------
    // framing counts
    // ----------------------------------------------------------------
    localparam logic [2:0] DUMMY_LEGACY = 3'h4;
    localparam logic [2:0] DUMMY_FAST   = 3'h1;
    localparam logic [2:0] DUMMY_NONE   = 3'h0;
    localparam logic [2:0] DUMMY_PAGE   = 3'h4;
    localparam logic [2:0] DUMMY_BUF    = 3'h1;
    localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
    localparam logic [2:0] LAST_BIT       = 3'h7;

    // ----------------------------------------------------------------
    // address layout
    // ----------------------------------------------------------------
    localparam int PAGE_BITS = 12;
    localparam int COL_BITS  = 10;
    localparam int LONG_PAGE_LSB  = 10;
    localparam int SHORT_PAGE_LSB = 9;
    localparam logic [COL_BITS-1:0] LAST_COL_LONG  = 10'h20F;
    localparam logic [COL_BITS-1:0] LAST_COL_SHORT = 10'h1FF;

    // ----------------------------------------------------------------
    // data path
    // ----------------------------------------------------------------
    localparam int         FIFO_WORDS = 32;
    localparam int         DATA_BITS  = 8;
    localparam logic [7:0] UNDERRUN_FILL = 8'hFF;

    typedef enum logic [1:0] {
        SRC_ARRAY = 2'h0,
        SRC_BUF1  = 2'h1,
        SRC_BUF2  = 2'h2
    } sfr_src_e;

    typedef struct packed {
        logic       valid;
        sfr_src_e   src;
        logic       same_page;
        logic [2:0] dummies;
    } sfr_cmd_s;

    typedef struct packed {
        sfr_src_e              src;
        logic [PAGE_BITS-1:0]  page_number_field;
        logic [COL_BITS-1:0]   byte_in_page_field;
    } sfr_mem_req_s;

endpackage
`default_nettype wire

/* hdl/sfr_fifo.sv */
`default_nettype none
module sfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             flush_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_out  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_ptr != rd_ptr;
    assign out_data_out  = mem[rd_ptr[AW-1:0]];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_ready_in & out_valid_out;

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    // flush beats a simultaneous push or pop
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end
endmodule // sfr_fifo
`default_nettype wire

/* tb/sfr_read_seq_assertions.sv */
`default_nettype none
module sfr_read_seq_assertions
    import sfr_pkg::*;
(
    input wire logic         sys_clk_in,
    input wire logic         reset_n_in,
    input wire logic         cs_n_in,
    input wire logic         sck_in,
    input wire logic         page_512_in,
    input wire logic         so_out,
    input wire logic         so_oe_n_out,
    input wire logic         mem_rd_out,
    input wire sfr_mem_req_s mem_req_out
);
    // ----------------------------------------------------------------
    // header rise count
    // ----------------------------------------------------------------
    logic [5:0] rises;
    logic       sck_q;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck_in;
        end
    end

    // saturates so a long stream cannot wrap the count back below 32
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rises <= 6'h00;
        end else if (cs_n_in) begin
            rises <= 6'h00;
        end else if (sck_in && !sck_q && rises != 6'h3F) begin
            rises <= rises + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    oe_off_a: assert property (cs_n_in |=> so_oe_n_out)
        else $error("output still driven after select rise");
    oe_hold_a: assert property (!so_oe_n_out && !cs_n_in |=> !so_oe_n_out)
        else $error("output released while selected");
    oe_late_a: assert property ($fell(so_oe_n_out) |-> rises >= 6'h20)
        else $error("output driven before header complete");
    so_edge_a: assert property (!so_oe_n_out && $changed(so_out) |->
        $past(sck_in, 2) && !$past(sck_in))
        else $error("output bit changed without clock fall");
    oe_edge_a: assert property ($fell(so_oe_n_out) |-> $past(sck_in, 2) && !$past(sck_in))
        else $error("output enabled without clock fall");
    rd_pulse_a: assert property (mem_rd_out |=> !mem_rd_out)
        else $error("read strobe longer than one cycle");
    req_hold_a: assert property (!mem_rd_out |-> $stable(mem_req_out))
        else $error("request moved between strobes");
    col_max_a: assert property (mem_rd_out |-> mem_req_out.byte_in_page_field <=
        (page_512_in ? LAST_COL_SHORT : LAST_COL_LONG))
        else $error("column beyond last byte");
    buf_page_a: assert property (mem_rd_out && mem_req_out.src != SRC_ARRAY |->
        mem_req_out.page_number_field == 12'h000)
        else $error("buffer read carries a page");

    cover property ($fell(so_oe_n_out));
    cover property (mem_rd_out && mem_req_out.src == SRC_BUF2);
    cover property (mem_rd_out && mem_req_out.page_number_field == 12'hFFF);
endmodule // sfr_read_seq_assertions

bind sfr_read_seq sfr_read_seq_assertions chk_u (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .cs_n_in    (cs_n_in),
    .sck_in     (sck_in),
    .page_512_in(page_512_in),
    .so_out     (so_out),
    .so_oe_n_out(so_oe_n_out),
    .mem_rd_out (mem_rd_out),
    .mem_req_out(mem_req_out)
);
`default_nettype wire

/* tb/sfr_mem_model.sv */
`default_nettype none
module sfr_mem_model
    import sfr_pkg::*;
(
    input  wire logic         mem_rd_in,
    input  wire sfr_mem_req_s mem_req_in,
    output logic [7:0]        mem_data_out
);
    // ----------------------------------------------------------------
    // zero-wait memory
    // ----------------------------------------------------------------
    logic [7:0] tag;

    // byte tagged with source, page and column so a wrong fetch shows
    assign tag = mem_req_in.byte_in_page_field[7:0] ^ {mem_req_in.page_number_field[3:0],
        mem_req_in.byte_in_page_field[9:8], mem_req_in.src};

    // sequencer captures while its strobe is high; off the strobe the
    // byte is inverted so a capture in the wrong cycle cannot match
    assign mem_data_out = mem_rd_in ? tag : ~tag;
endmodule // sfr_mem_model
`default_nettype wire

/* tb/test_serial_flash_read_commands.sv */
`default_nettype none
module test_serial_flash_read_commands;
    timeunit 1ns;
    timeprecision 1ns;
    import sfr_pkg::*;

    logic         sys_clk_in;
    logic         reset_n_in;
    logic         cs_n_in;
    logic         sck_in;
    logic         si_in;
    logic         page_512_in;
    logic [7:0]   mem_data;
    logic         so_out;
    logic         so_oe_n_out;
    logic         mem_rd_out;
    sfr_mem_req_s mem_req_out;
    logic [7:0]   rx_q[$];
    logic         oe_seen;
    int           error_cnt = 0;
    int           checks_done = 0;
    int           cyc = 0;

    sfr_read_seq #(.FIFO_DEPTH(FIFO_WORDS)) dut_u (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .cs_n_in    (cs_n_in),
        .sck_in     (sck_in),
        .si_in      (si_in),
        .page_512_in(page_512_in),
        .mem_data_in(mem_data),
        .so_out     (so_out),
        .so_oe_n_out(so_oe_n_out),
        .mem_rd_out (mem_rd_out),
        .mem_req_out(mem_req_out)
    );

    sfr_mem_model mem_u (
        .mem_rd_in   (mem_rd_out),
        .mem_req_in  (mem_req_out),
        .mem_data_out(mem_data)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) begin
        if (!so_oe_n_out) oe_seen <= 1'b1;
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] pat(input logic [1:0] s, input int pg, input int col);
        logic [11:0] p;
        logic [9:0]  c;
        p = pg[11:0];
        c = col[9:0];
        return c[7:0] ^ {p[3:0], c[9:8], s};
    endfunction

    // ten system cycles per bit keeps the prefetch ahead of the host
    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_in = 1'b0;
            si_in = tx[i];
            repeat (5) @(negedge sys_clk_in);
            rx[i] = so_out;
            sck_in = 1'b1;
            repeat (5) @(negedge sys_clk_in);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] adr, input int nd, input int n,
                       input logic mode3);
        logic [7:0] b;
        rx_q.delete();
        sck_in = mode3;
        @(negedge sys_clk_in);
        oe_seen = 1'b0;
        cs_n_in = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        spi_byte(op, b);
        for (int k = 2; k >= 0; k--) spi_byte(adr[8*k +: 8], b);
        repeat (nd) spi_byte(8'hA5, b);
        repeat (n) begin
            spi_byte(8'h00, b);
            rx_q.push_back(b);
        end
        sck_in = mode3;
        cs_n_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        chk("oe_off", 8'h01, {7'h00, so_oe_n_out});
    endtask

    task automatic run_chk(input string what, input logic [1:0] s, input int pg, input int col,
                           input int last, input logic same);
        foreach (rx_q[i]) begin
            chk(what, pat(s, pg, col), rx_q[i]);
            if (col == last) begin
                col = 0;
                if (!same) pg = (pg + 1) % 4096;
            end else begin
                col++;
            end
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("reset_oe", 8'h01, {7'h00, so_oe_n_out});
        chk("reset_rd", 8'h00, {7'h00, mem_rd_out});
        $display("reset test done");
    endtask

    task automatic t_array();
        logic [7:0] ops[3] = '{OP_ARRAY_LEGACY, OP_ARRAY_FAST, OP_ARRAY_SLOW};
        int         dm[3] = '{4, 1, 0};
        page_512_in = 1'b0;
        for (int j = 0; j < 3; j++) begin
            cmd(ops[j], {2'b00, 12'h005, 10'h20E}, dm[j], 4, j == 2);
            run_chk("array", 2'h0, 5, 526, 527, 1'b0);
        end
        $display("array test done");
    endtask

    task automatic t_wrap();
        page_512_in = 1'b1;
        cmd(OP_ARRAY_FAST, {3'b000, 12'hFFF, 9'h1FE}, 1, 4, 1'b0);
        run_chk("wrap", 2'h0, 4095, 510, 511, 1'b0);
        $display("wrap test done");
    endtask

    task automatic t_page();
        page_512_in = 1'b0;
        cmd(OP_PAGE_READ, {2'b00, 12'h007, 10'h20E}, 4, 4, 1'b1);
        run_chk("page", 2'h0, 7, 526, 527, 1'b1);
        $display("page test done");
    endtask

    task automatic t_buf();
        logic [7:0] ops[4] = '{OP_BUF1_FAST, OP_BUF1_SLOW, OP_BUF2_FAST, OP_BUF2_SLOW};
        page_512_in = 1'b0;
        for (int j = 0; j < 4; j++) begin
            cmd(ops[j], {14'h3FFF, 10'h20F}, 1, 3, 1'b0);
            run_chk("buf", (j < 2) ? 2'h1 : 2'h2, 0, 527, 527, 1'b1);
        end
        page_512_in = 1'b1;
        cmd(OP_BUF2_FAST, {15'h7FFF, 9'h1FF}, 1, 3, 1'b0);
        run_chk("buf_short", 2'h2, 0, 511, 511, 1'b1);
        $display("buffer test done");
    endtask

    task automatic t_bad();
        cmd(8'h55, 24'h000000, 0, 2, 1'b0);
        chk("oe_unknown", 8'h00, {7'h00, oe_seen});
        $display("unknown opcode test done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        reset_n_in = 1'b0;
        cs_n_in = 1'b1;
        sck_in = 1'b0;
        si_in = 1'b0;
        page_512_in = 1'b0;
        oe_seen = 1'b0;
        repeat (12) @(negedge sys_clk_in);
        t_reset();
        reset_n_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        t_array();
        t_wrap();
        t_page();
        t_buf();
        t_bad();
        stop_test();
    end
endmodule // test_serial_flash_read_commands
`default_nettype wire
